// [hdl/cpc_regs.vh]
`ifndef CPC_REGS_VH
`define CPC_REGS_VH
// Operation
// [R1] Every gate output owns a 5-bit forward selector and a 5-bit backward selector.
// [R2] The selector pairs cover gate outputs 01 to 22.
// [R3] Code 00h gives the low rail when scan direction is 0 and the high rail when it is 1.
// [R4] Code 01h gives the high rail when scan direction is 0 and the low rail when it is 1.
// [R5] Codes 02h-05h are fixed low/ground/source/high levels, 06h-13h route timing, 14h-17h reserved.
// [R6] The host selects page 3 before writing gate selectors, else those writes miss them.
// [R7] The page changes only on the byte sequence 98h, 81h, page number to the page selector.
// [R8] Page numbers 00h-0Ah are valid, others reserved, and page 3 is selected after reset.
// [R9] Lane control bit 7 picks the data lane count, reset value 80h, other bits zero.
// [R10] Spread control bit 7 enables spreading and both spread registers reset to 00h.
// [R11] The host writes 80h and 17h for one percent spreading.
// [R12] The host writes 90h and 0Bh for two percent spreading; other pairs are reserved.
// [R13] Pump register bit 7 picks idle-video behaviour and resets to B0h.
// [R14] With that bit at 0 and video stopped the pumps run and the smallest gamma level is shown.
// [R15] The backward swap bit at 1 exchanges the backward gate mapping, 0 keeps it.
// [R16] All registers stay writable in every power state and reload defaults on any reset.

// ============================================================
// Command pages
`define CPC_PAGE_GATE      8'h03
`define CPC_PAGE_LINK      8'h04
`define CPC_PAGE_MAX       8'h0A
`define CPC_PAGE_RESET     8'h03
`define CPC_KEY1           8'h98
`define CPC_KEY2           8'h81
// ============================================================
// Offsets on page 3
`define CPC_ADDR_PAGE_SEL  8'hFF
`define CPC_ADDR_SWAP      8'h5E
`define CPC_ADDR_FW_BASE   8'h5F
`define CPC_ADDR_BW_BASE   8'h75
`define CPC_GATE_COUNT     22
`define CPC_TABLE_SIZE     8'h16
// ============================================================
// Offsets on page 4
`define CPC_ADDR_LANE      8'h00
`define CPC_ADDR_SSC_CTL   8'h0B
`define CPC_ADDR_SSC_CNT   8'h0E
`define CPC_ADDR_PUMP      8'h21
// ============================================================
// Reset values and fields
`define CPC_LANE_RESET     8'h80
`define CPC_SSC_RESET      8'h00
`define CPC_PUMP_RESET     8'hB0
`define CPC_SWAP_RESET     8'h00
`define CPC_SEL_RESET      5'h00
`define CPC_LANE_MASK      8'h80
`define CPC_SSC_CTL_MASK   8'hF0
`define CPC_SWAP_MASK      8'h11
`define CPC_PUMP_FIXED     7'h30
`define CPC_BIT_TOP        7
`define CPC_BIT_BW_SWAP    4
`define CPC_BIT_FW_SWAP    0
`define CPC_STEP_FIELD     6:4
`define CPC_SEL_FIELD      4:0
// ============================================================
// Gate output level codes
`define CPC_LVL_LOW        3'h0
`define CPC_LVL_GND        3'h1
`define CPC_LVL_SRC        3'h2
`define CPC_LVL_HIGH       3'h3
`define CPC_LVL_TIMING     3'h4
`define CPC_LVL_RSVD       3'h5
`define CPC_SEL_FLIP_LOW   5'h00
`define CPC_SEL_FLIP_HIGH  5'h01
`define CPC_SEL_LOW        5'h02
`define CPC_SEL_GND        5'h03
`define CPC_SEL_SRC        5'h04
`define CPC_SEL_HIGH       5'h05
`define CPC_SEL_TIM_FIRST  5'h06
`define CPC_SEL_TIM_LAST   5'h13
`define CPC_SEL_TIM_BIAS   5'h06
`endif

// [hdl/cpc_gate_decode.v]
`timescale 1ns/1ps
`include "cpc_regs.vh"
// ============================================================
// Turns one 5-bit selector into a level class and timing source index
module cpc_gate_decode (
	input  wire [4:0] sel,
	input  wire       gate_scan_direction,
	output reg  [2:0] level,
	output reg  [3:0] timing_index
);
	reg [4:0] tim_offset;
	// Codes beyond 13h fall to reserved, a level class of their own apart from the low rail
	always @* begin
		timing_index = 4'h0;
		tim_offset   = sel - `CPC_SEL_TIM_BIAS;
		case (sel)
			`CPC_SEL_FLIP_LOW:  level = gate_scan_direction ? `CPC_LVL_HIGH : `CPC_LVL_LOW; // [R3]
			`CPC_SEL_FLIP_HIGH: level = gate_scan_direction ? `CPC_LVL_LOW : `CPC_LVL_HIGH; // [R4]
			`CPC_SEL_LOW:  level = `CPC_LVL_LOW;  // [R5]
			`CPC_SEL_GND:  level = `CPC_LVL_GND;  // [R5]
			`CPC_SEL_SRC:  level = `CPC_LVL_SRC;  // [R5]
			`CPC_SEL_HIGH: level = `CPC_LVL_HIGH; // [R5]
			default: begin
				if (sel >= `CPC_SEL_TIM_FIRST && sel <= `CPC_SEL_TIM_LAST) begin
					level        = `CPC_LVL_TIMING; // [R5]
					timing_index = tim_offset[3:0];
				end else begin
					level = `CPC_LVL_RSVD; // [R5]
				end
			end
		endcase
	end
endmodule

// [hdl/cpc_config_regs.v]
`timescale 1ns/1ps
`include "cpc_regs.vh"
// ============================================================
// Command page configuration registers, written over the command link
module cpc_config_regs (
	input  wire                   ref_clk,
	input  wire                   rst_n,
	input  wire                   sw_reset,
	input  wire                   cmd_wr,
	input  wire [7:0]             cmd_addr,
	input  wire [7:0]             cmd_data,
	input  wire                   cmd_first,
	input  wire                   cmd_rd,
	output reg  [7:0]             cmd_rdata,
	input  wire                   gate_scan_direction,
	input  wire                   scan_backward,
	input  wire                   video_stopped,
	output reg  [7:0]             active_page,
	output wire                   lane_select,
	output wire                   spread_clock_enable,
	output wire [2:0]             spread_step_setting,
	output wire [7:0]             spread_count_setting,
	output wire                   idle_video_pump_mode,
	output wire                   pump_keep_running,
	output wire                   show_min_gamma,
	output wire                   reverse_scan_swap,
	output wire                   forward_scan_swap,
	output wire [66-1:0]          panel_gate_levels,
	output wire [88-1:0]          panel_gate_timing
);
	localparam N = `CPC_GATE_COUNT;
	// Page selector sequencer states (one-hot)
	localparam ST_IDLE = 3'b001;
	localparam ST_KEY1 = 3'b010;
	localparam ST_KEY2 = 3'b100;

	reg [2:0] seq_reg;
	reg [2:0] seq_next;
	reg [7:0] page_next;
	reg [7:0] lane_reg;
	reg [7:0] ssc_ctl_reg;
	reg [7:0] ssc_cnt_reg;
	reg [7:0] pump_reg;
	reg [7:0] swap_reg;
	reg [4:0] fw_sel_reg [0:N-1];
	reg [4:0] bw_sel_reg [0:N-1];
	integer   k;
	wire      any_reset = !rst_n || sw_reset; // [R16]
	wire      page3_wr  = cmd_wr && active_page == `CPC_PAGE_GATE; // [R6]
	wire      page4_wr  = cmd_wr && active_page == `CPC_PAGE_LINK;
	wire      sel_wr    = cmd_wr && cmd_addr == `CPC_ADDR_PAGE_SEL;

	// True when an address falls inside a selector table of 22 entries
	function in_table;
		input [7:0] addr;
		input [7:0] base;
		reg   [7:0] offset;
		begin
			// The lower bound stops a wrapped offset from hitting the table
			offset   = addr - base;
			in_table = addr >= base && offset < `CPC_TABLE_SIZE;
		end
	endfunction

	// Table position of the addressed entry; only used once in_table agrees
	wire [7:0] fw_index = cmd_addr - `CPC_ADDR_FW_BASE;
	wire [7:0] bw_index = cmd_addr - `CPC_ADDR_BW_BASE;
	wire       fw_hit   = page3_wr && in_table(cmd_addr, `CPC_ADDR_FW_BASE);
	wire       bw_hit   = page3_wr && in_table(cmd_addr, `CPC_ADDR_BW_BASE);

	// ============================================================
	// Page selector: key, key, page; any other write restarts the hunt
	always @* begin
		seq_next  = seq_reg;
		page_next = active_page;
		if (sel_wr) begin
			case (seq_reg)
				ST_IDLE: begin
					if (cmd_first && cmd_data == `CPC_KEY1)
						seq_next = ST_KEY1; // [R7]
					else
						seq_next = ST_IDLE;
				end
				ST_KEY1: begin
					if (cmd_data == `CPC_KEY2)
						seq_next = ST_KEY2; // [R7]
					else
						seq_next = ST_IDLE;
				end
				ST_KEY2: begin
					seq_next = ST_IDLE;
					// Reserved pages are dropped so the bank never lands nowhere
					if (cmd_data <= `CPC_PAGE_MAX)
						page_next = cmd_data; // [R8]
				end
				default: seq_next = ST_IDLE;
			endcase
		end else if (cmd_wr) begin
			// A write elsewhere breaks the key, so a stray key byte cannot arm it
			seq_next = ST_IDLE; // [R7]
		end
	end

	// Selector state and page; both reload on either reset
	always @(posedge ref_clk) begin
		if (any_reset) begin
			seq_reg     <= ST_IDLE;
			active_page <= `CPC_PAGE_RESET; // [R8] [R16]
		end else begin
			seq_reg     <= seq_next;
			active_page <= page_next;
		end
	end

	// ============================================================
	// Page 4 registers, writable in all power states
	always @(posedge ref_clk) begin
		if (any_reset) begin
			lane_reg    <= `CPC_LANE_RESET; // [R9]
			ssc_ctl_reg <= `CPC_SSC_RESET;  // [R10]
			ssc_cnt_reg <= `CPC_SSC_RESET;  // [R10]
			pump_reg    <= `CPC_PUMP_RESET; // [R13]
		end else if (page4_wr) begin
			if (cmd_addr == `CPC_ADDR_LANE)
				lane_reg <= cmd_data & `CPC_LANE_MASK; // [R9]
			if (cmd_addr == `CPC_ADDR_SSC_CTL)
				ssc_ctl_reg <= cmd_data & `CPC_SSC_CTL_MASK; // [R10]
			if (cmd_addr == `CPC_ADDR_SSC_CNT)
				ssc_cnt_reg <= cmd_data;
			// Low bits are fixed pattern, only the mode bit moves
			if (cmd_addr == `CPC_ADDR_PUMP)
				pump_reg <= {cmd_data[`CPC_BIT_TOP], `CPC_PUMP_FIXED}; // [R13]
		end
	end

	// ============================================================
	// Page 3 swap bits and selector tables
	always @(posedge ref_clk) begin
		if (any_reset)
			swap_reg <= `CPC_SWAP_RESET;
		else if (page3_wr && cmd_addr == `CPC_ADDR_SWAP)
			swap_reg <= cmd_data & `CPC_SWAP_MASK; // [R15]
	end

	// One process owns both tables so every entry has a single driver
	always @(posedge ref_clk) begin
		if (any_reset) begin
			for (k = 0; k < N; k = k + 1) begin
				fw_sel_reg[k] <= `CPC_SEL_RESET;
				bw_sel_reg[k] <= `CPC_SEL_RESET;
			end
		end else begin
			// Bits 7:5 of a selector byte have no storage and are dropped
			if (fw_hit)
				fw_sel_reg[fw_index[4:0]] <= cmd_data[`CPC_SEL_FIELD]; // [R1] [R2]
			if (bw_hit)
				bw_sel_reg[bw_index[4:0]] <= cmd_data[`CPC_SEL_FIELD]; // [R1] [R2]
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gate
			wire [4:0] eff_sel;
			wire [2:0] lvl;
			wire [3:0] tix;
			// Backward exchange mirrors the table end for end
			assign eff_sel = !scan_backward ? fw_sel_reg[g] :
				(swap_reg[`CPC_BIT_BW_SWAP] ? bw_sel_reg[N-1-g] : bw_sel_reg[g]); // [R15]
			cpc_gate_decode u_dec (
				.sel                 (eff_sel),
				.gate_scan_direction (gate_scan_direction),
				.level               (lvl),
				.timing_index        (tix)
			);
			assign panel_gate_levels[g*3 +: 3] = lvl;
			assign panel_gate_timing[g*4 +: 4] = tix;
		end
	endgenerate

	// ============================================================
	// Read back; the page selector is write-only and reads zero
	reg [7:0] rdata_next;
	always @* begin
		rdata_next = 8'h00;
		if (active_page == `CPC_PAGE_LINK) begin
			case (cmd_addr)
				`CPC_ADDR_LANE:    rdata_next = lane_reg;
				`CPC_ADDR_SSC_CTL: rdata_next = ssc_ctl_reg;
				`CPC_ADDR_SSC_CNT: rdata_next = ssc_cnt_reg;
				`CPC_ADDR_PUMP:    rdata_next = pump_reg;
				default:           rdata_next = 8'h00;
			endcase
		end else if (active_page == `CPC_PAGE_GATE) begin
			if (cmd_addr == `CPC_ADDR_SWAP)
				rdata_next = swap_reg;
			else if (in_table(cmd_addr, `CPC_ADDR_FW_BASE))
				rdata_next = {3'h0, fw_sel_reg[fw_index[4:0]]};
			else if (in_table(cmd_addr, `CPC_ADDR_BW_BASE))
				rdata_next = {3'h0, bw_sel_reg[bw_index[4:0]]};
		end
	end

	// Read data stands until the next read, so the host may fetch it late
	always @(posedge ref_clk) begin
		if (any_reset)
			cmd_rdata <= 8'h00;
		else if (cmd_rd)
			cmd_rdata <= rdata_next;
	end

	// ============================================================
	// Decoded controls
	assign lane_select          = lane_reg[`CPC_BIT_TOP];    // [R9]
	assign spread_clock_enable  = ssc_ctl_reg[`CPC_BIT_TOP]; // [R10]
	assign spread_step_setting  = ssc_ctl_reg[`CPC_STEP_FIELD];
	assign spread_count_setting = ssc_cnt_reg;
	assign idle_video_pump_mode = pump_reg[`CPC_BIT_TOP];    // [R13]
	// Both settings of the pump bit keep the rail pumps running
	assign pump_keep_running    = 1'b1;                      // [R14]
	assign show_min_gamma       = video_stopped && !idle_video_pump_mode; // [R14]
	assign reverse_scan_swap    = swap_reg[`CPC_BIT_BW_SWAP];
	assign forward_scan_swap    = swap_reg[`CPC_BIT_FW_SWAP];
endmodule

// [testbench/cpc_host.sv]
`timescale 1ns/1ps
// ============================================================
// Command link host: each byte goes out 1 ns after a clock edge
module cpc_host (
	input  wire        ref_clk,
	input  wire  [7:0] cmd_rdata,
	output logic       cmd_wr,
	output logic       cmd_rd,
	output logic       cmd_first,
	output logic [7:0] cmd_addr,
	output logic [7:0] cmd_data
);
	initial {cmd_wr, cmd_rd, cmd_first, cmd_addr, cmd_data} = 19'h0;
	// Byte left standing so that the next one can follow back to back
	task send(input logic [7:0] a, d, input logic f);
		cmd_wr = 1'b1;
		cmd_first = f;
		cmd_addr = a;
		cmd_data = d;
		@(posedge ref_clk) #1;
	endtask
	// Released data is flipped so that a stale byte never looks valid
	task idle;
		cmd_wr = 1'b0;
		cmd_first = 1'b0;
		cmd_data = ~cmd_data;
		@(posedge ref_clk) #1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		cmd_rd = 1'b1;
		cmd_addr = a;
		@(posedge ref_clk) #1;
		v = cmd_rdata;
		cmd_rd = 1'b0;
		@(posedge ref_clk) #1;
	endtask
	// Key bytes go unbroken; any write between them would restart it
	task page(input logic [7:0] p);
		send(8'hFF, 8'h98, 1'b1);
		send(8'hFF, 8'h81, 1'b0);
		send(8'hFF, p, 1'b0);
		idle;
	endtask
endmodule

// [testbench/cpc_config_regs_chk.sv]
`timescale 1ns/1ps
// ============================================================
// Port checker for the configuration registers
module cpc_config_regs_chk (
	input wire        ref_clk,
	input wire        rst_n,
	input wire        sw_reset,
	input wire        cmd_wr,
	input wire  [7:0] cmd_addr,
	input wire  [7:0] cmd_data,
	input wire        cmd_first,
	input wire        cmd_rd,
	input wire  [7:0] cmd_rdata,
	input wire        scan_backward,
	input wire        video_stopped,
	input wire  [7:0] active_page,
	input wire        lane_select,
	input wire        idle_video_pump_mode,
	input wire        show_min_gamma,
	input wire [65:0] panel_gate_levels
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire       top_bit = cmd_data[7];
	wire [2:0] code_lo = cmd_data[2:0];
	wire       on_page4 = active_page == 8'h04;
	wire       dflt = active_page == 8'h03 && lane_select && idle_video_pump_mode;
	wire       page_wr = cmd_wr && cmd_addr == 8'hFF && !sw_reset;
	// Three-byte key; the last byte must be a legal page
	sequence key_seq;
		page_wr && cmd_first && cmd_data == 8'h98 ##1 page_wr && cmd_data == 8'h81
		##1 page_wr && cmd_data <= 8'h0A;
	endsequence
	a_page_switch: assert property (key_seq |=> active_page == $past(cmd_data))
		else $error("page key not taken");
	a_page_hold: assert property (!page_wr && !sw_reset |=> $stable(active_page))
		else $error("page moved without key");
	a_page_range: assert property (page_wr && cmd_data > 8'h0A |=> $stable(active_page))
		else $error("reserved page taken");
	a_hw_defaults: assert property ($rose(rst_n) |-> dflt)
		else $error("defaults missing after reset");
	a_sw_defaults: assert property (sw_reset |=> dflt)
		else $error("defaults missing after soft reset");
	a_lane_write: assert property (cmd_wr && cmd_addr == 8'h00 && on_page4 && !sw_reset
		|=> lane_select == $past(top_bit))
		else $error("lane bit not written");
	a_pump_read: assert property (cmd_rd && cmd_addr == 8'h21 && on_page4 && !sw_reset
		|=> cmd_rdata == {idle_video_pump_mode, 7'h30})
		else $error("pump readback wrong");
	a_min_gamma: assert property (show_min_gamma == (video_stopped && !idle_video_pump_mode))
		else $error("idle gamma wrong");
	a_fixed_level: assert property (cmd_wr && cmd_addr == 8'h5F && active_page == 8'h03
		&& cmd_data >= 8'h02 && cmd_data <= 8'h05 && !sw_reset && !scan_backward
		##1 !scan_backward |-> panel_gate_levels[2:0] == $past(code_lo) - 3'h2)
		else $error("fixed level wrong");
	a_page_read: assert property (cmd_rd && cmd_addr == 8'hFF && !sw_reset |=> cmd_rdata == 8'h00)
		else $error("selector readable");
endmodule
bind cpc_config_regs cpc_config_regs_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.sw_reset(sw_reset), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
	.cmd_first(cmd_first), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .scan_backward(scan_backward),
	.video_stopped(video_stopped), .active_page(active_page), .lane_select(lane_select),
	.idle_video_pump_mode(idle_video_pump_mode), .show_min_gamma(show_min_gamma),
	.panel_gate_levels(panel_gate_levels));

// [testbench/cpc_config_regs_tb.sv]
`timescale 1ns/1ps
// ============================================================
// Bench: the host writes and reads, the bench compares
module cpc_config_regs_tb;
	logic        ref_clk, rst_n, sw_reset, gsd, scan_backward, video_stopped;
	wire         cmd_wr, cmd_rd, cmd_first, lane_sel, ssc_en, pump, keep, min_g, bw_swap, fw_swap;
	wire  [7:0]  cmd_addr, cmd_data, cmd_rdata, active_page, ssc_cnt;
	wire  [2:0]  ssc_step;
	wire  [65:0] lvl_o;
	wire  [87:0] tim_o;
	int          bad_count, compares, i;
	logic [7:0]  rv;
	// Address, written byte, expected readback
	logic [23:0] tbl [6] = '{24'h000000, 24'h0B8080, 24'h0E1717, 24'h0B9090, 24'h0E0B0B, 24'h210030};
	cpc_host h_u (.ref_clk(ref_clk), .cmd_rdata(cmd_rdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_first(cmd_first), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
	cpc_config_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .sw_reset(sw_reset), .cmd_wr(cmd_wr),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_first(cmd_first), .cmd_rd(cmd_rd),
		.cmd_rdata(cmd_rdata), .gate_scan_direction(gsd), .scan_backward(scan_backward),
		.video_stopped(video_stopped), .active_page(active_page), .lane_select(lane_sel),
		.spread_clock_enable(ssc_en), .spread_step_setting(ssc_step), .spread_count_setting(ssc_cnt),
		.idle_video_pump_mode(pump), .pump_keep_running(keep), .show_min_gamma(min_g),
		.reverse_scan_swap(bw_swap), .forward_scan_swap(fw_swap), .panel_gate_levels(lvl_o),
		.panel_gate_timing(tim_o));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input string nm, input logic [87:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task rdc(input logic [7:0] a, e);
		h_u.rd(a, rv);
		chk("readback", rv, e);
	endtask
	task end_sim;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Expected class of one selector code, worked out independently
	function automatic logic [2:0] lvl(input logic [4:0] c, input logic g);
		if (c < 5'h02)
			return (c[0] ^ g) ? 3'h3 : 3'h0;
		if (c < 5'h06)
			return c[2:0] - 3'h2;
		return (c < 5'h14) ? 3'h4 : 3'h5;
	endfunction
	// Watchdog; no task waits on the design, so this only guards the run
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		end_sim;
	end
	initial begin
		{rst_n, sw_reset, gsd, scan_backward, video_stopped} = 5'h0;
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		chk("defaults", {active_page, lane_sel, ssc_en, ssc_step, ssc_cnt, pump}, 22'h00E001);
		chk("gates low", lvl_o, 66'h0);
		gsd = 1'b1;
		h_u.idle;
		chk("gates high", lvl_o, {22{3'h3}});
		// Codes 00h to 17h back to back on gate 1, forward scan
		for (i = 0; i < 24; i++) begin
			h_u.send(8'h5F, i[7:0], 1'b1);
			chk("code", {tim_o[3:0], lvl_o[2:0]}, {(i > 5 && i < 20) ? i[3:0] - 4'h6 : 4'h0,
				lvl(i[4:0], 1'b1)});
		end
		h_u.idle;
		{gsd, scan_backward} = 2'b01;
		h_u.send(8'h8A, 8'h01, 1'b1);
		chk("bw plain", {lvl_o[65:63], lvl_o[2:0]}, 6'o30);
		h_u.send(8'h5E, 8'hFF, 1'b1);
		chk("bw swap", {fw_swap, bw_swap, lvl_o[65:63], lvl_o[2:0]}, 8'hC3);
		h_u.idle;
		scan_backward = 1'b0;
		h_u.send(8'hFF, 8'h98, 1'b1);
		h_u.send(8'hFF, 8'h00, 1'b0);
		h_u.send(8'hFF, 8'h05, 1'b0);
		h_u.idle;
		chk("key broken", active_page, 8'h03);
		h_u.page(8'h0B);
		chk("page kept", active_page, 8'h03);
		h_u.page(8'h04);
		chk("page 4", active_page, 8'h04);
		h_u.send(8'h5F, 8'h05, 1'b1);
		h_u.idle;
		chk("gate locked", lvl_o[2:0], 3'h5);
		foreach (tbl[k]) begin
			h_u.send(tbl[k][23:16], tbl[k][15:8], 1'b1);
			h_u.idle;
			rdc(tbl[k][23:16], tbl[k][7:0]);
		end
		video_stopped = 1'b1;
		h_u.idle;
		chk("page 4 outs", {lane_sel, ssc_en, ssc_step, ssc_cnt, keep, min_g}, 15'h242F);
		rdc(8'h30, 8'h00);
		rdc(8'hFF, 8'h00);
		sw_reset = 1'b1;
		h_u.idle;
		sw_reset = 1'b0;
		chk("soft reset", {active_page, lane_sel, ssc_en, ssc_step, ssc_cnt, pump}, 22'h00E001);
		chk("gamma off", min_g, 1'b0);
		end_sim;
	end
endmodule
